// ===== logic/cqm_regs.vh
// Register map, field positions, reset values and timing of the monitor.
//
// Summary of operation
// - Slicer error is taken against -96,-32,32,96 (gigabit) or -128,0,128 (fast).
// - Error magnitude is clamped to 32 in gigabit mode and 64 in fast mode.
// - All measurements advance only while the measurement enable bit is set.
// - Filter adds (term minus state) each symbol; gigabit error doubled before squaring.
// - Square select squares the scaled error, otherwise the absolute value is filtered.
// - Mean filter weights the difference by two to the minus mean shift.
// - Mean square error is filtered value over two to output shift, max 511.
// - Mean filter output is latched every 65,536 symbols for the mean results.
// - Software writes capture with pair number; capture self-clears, results are loaded.
// - Largest mean square error since the last read of the mean square error register is kept separately.
// - Quality index is 7 at or below threshold seven, down to 0 above one.
// - A capture loads the selected pair's current quality index.
// - Lowest quality index since last read sits beside the current index.
// - A capture loads the selected pair's latched mean slicer error.
// - Peak path filters with peak shift; highest value per 65,536 symbols saved.
// - Peak error is saved peak over two to peak scale plus 3, max 63.
// - A capture loads current and worst peak error into one register.
`ifndef CQM_REGS_VH
`define CQM_REGS_VH
`define CQM_OFS_CONFIG 6'h00
`define CQM_OFS_THRESH1 6'h04
`define CQM_OFS_THRESH7 6'h1C
`define CQM_OFS_MSE 6'h20
`define CQM_OFS_MSE_WORST 6'h24
`define CQM_OFS_QUALITY 6'h28
`define CQM_OFS_SLICER 6'h2C
`define CQM_OFS_PEAK 6'h30
`define CQM_BIT_ENABLE 0
`define CQM_BIT_SQUARE 1
`define CQM_BIT_GIGABIT 2
`define CQM_BIT_CAPTURE 3
`define CQM_FLD_CHANNEL 5:4
`define CQM_FLD_MEAN_FILTER_SHIFT 11:8
`define CQM_FLD_PEAK_FILTER_SHIFT 15:12
`define CQM_FLD_MEAN_OUTPUT_SHIFT 19:16
`define CQM_FLD_PEAK_OUTPUT_SHIFT 23:20
`define CQM_CONFIG_RESET 32'h0000_0000
`define CQM_CONFIG_WMASK 32'h00FF_FF37
`define CQM_THRESH_RESET 9'h000
`define CQM_MSE_MAX 13'h01FF
`define CQM_PEAK_MAX 13'h003F
`define CQM_PEAK_EXTRA_SHIFT 5'h03
`define CQM_PERIOD_SYMBOLS 65536
`define CQM_PERIOD_US 524288
`define CQM_PERIOD_LAST 16'hFFFF
`endif

// ===== logic/cqm_lpf.v
// First-order low pass filter with a power-of-two weighting.
`timescale 1ns/1ns
`default_nettype none
module cqm_lpf #(
    parameter IW = 13,
    parameter FW = 16
) (
    input wire clk_sys_in,
    input wire rstn_in,
    input wire step_in,
    input wire [IW-1:0] term_in,
    input wire [3:0] shift_in,
    output wire [IW-1:0] state_out
);
    reg [IW+FW-1:0] state_reg;
    wire signed [IW+FW:0] diff_w;
    wire signed [IW+FW:0] step_w;

    // The fraction bits keep small differences alive at large shifts.
    assign diff_w = $signed({1'b0, term_in, {FW{1'b0}}}) -
        $signed({1'b0, state_reg});
    assign step_w = diff_w >>> shift_in;
    assign state_out = state_reg[IW+FW-1:FW];

    // State moves toward the term by a shifted fraction of the gap.
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= {(IW+FW){1'b0}};
        end else if (step_in) begin
            state_reg <= state_reg + step_w[IW+FW-1:0];
        end
    end
endmodule // cqm_lpf
`default_nettype wire

// ===== logic/cqm_quality.v
// Maps a mean square error onto a quality index from 0 to 7.
`timescale 1ns/1ns
`default_nettype none
module cqm_quality (
    input wire [8:0] mse_in,
    input wire [62:0] thresh_in,
    output reg [2:0] index_out
);
    integer n;

    // Threshold n sits at bits 9n-9; a higher index needs a lower error.
    always @* begin
        index_out = 3'h0;
        for (n = 1; n <= 7; n = n + 1) begin
            if (mse_in <= thresh_in[9*n-1 -: 9]) begin
                index_out = n[2:0];
            end
        end
    end
endmodule // cqm_quality
`default_nettype wire

// ===== logic/cqm_monitor.v
// Channel quality monitor: four-pair error filters and Avalon registers.
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "cqm_regs.vh"
module cqm_monitor #(
    parameter PAIRS = 4,
    parameter FRAC = 16
) (
    input wire clk_sys_in,
    input wire rstn_in,
    input wire sym_valid_in,
    input wire [35:0] sample_in,
    input wire [5:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [3:0] avs_byteenable_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out
);
    reg [31:0] config_reg;
    reg [62:0] thresh_reg;
    reg ack_reg;
    reg [15:0] sym_cnt_reg;
    reg [12:0] lat_reg [0:PAIRS-1];
    reg [12:0] pk_run_reg [0:PAIRS-1];
    reg [12:0] pk_sav_reg [0:PAIRS-1];
    reg [8:0] worst_mse_reg [0:PAIRS-1];
    reg [8:0] worst_qmse_reg [0:PAIRS-1];
    reg [5:0] worst_pk_reg [0:PAIRS-1];
    reg [1:0] cap_pair_reg;
    reg [8:0] cap_mse_reg;
    reg [8:0] cap_wmse_reg;
    reg [8:0] cap_qmse_reg;
    reg [8:0] cap_wqmse_reg;
    reg [12:0] cap_slicer_reg;
    reg [5:0] cap_pk_reg;
    reg [5:0] cap_wpk_reg;
    reg [31:0] cur_word;
    reg [31:0] wr_word;
    wire [12:0] term_w [0:PAIRS-1];
    wire [12:0] mean_w [0:PAIRS-1];
    wire [12:0] peak_w [0:PAIRS-1];
    wire [2:0] cap_q_w;
    wire [2:0] cap_wq_w;
    wire meas_en;
    wire step;
    wire period_end;
    wire req;
    wire wr_ack;
    wire rd_ack;
    wire capture;
    wire [4:0] mean_os;
    wire [4:0] peak_os;
    integer p;

    // Error term for one pair: slice, clamp, scale and optionally square.
    function [12:0] err_term;
        input [8:0] smp;
        input gig;
        input square;
        reg signed [9:0] sv;
        reg signed [9:0] lvl;
        reg signed [9:0] e;
        reg [9:0] mag;
        reg [6:0] m;
        begin
            sv = {smp[8], smp};
            // Nearest reference level decides the error origin.
            if (gig) begin
                if (sv < -10'sd64) lvl = -10'sd96;
                else if (sv < 10'sd0) lvl = -10'sd32;
                else if (sv < 10'sd64) lvl = 10'sd32;
                else lvl = 10'sd96;
            end else begin
                if (sv < -10'sd64) lvl = -10'sd128;
                else if (sv < 10'sd64) lvl = 10'sd0;
                else lvl = 10'sd128;
            end
            e = sv - lvl;
            mag = e[9] ? (~e + 10'h001) : e;
            // Clamping bounds the square at 4096 so 13 bits suffice.
            if (gig) begin
                m = (mag > 10'd32) ? 7'h20 : mag[6:0];
                m = {m[5:0], 1'b0};
            end else begin
                m = (mag > 10'd64) ? 7'h40 : mag[6:0];
            end
            if (square) err_term = m * m;
            else err_term = {6'h00, m};
        end
    endfunction

    // Shift right and saturate at a ceiling.
    function [12:0] shr_sat;
        input [12:0] v;
        input [4:0] s;
        input [12:0] lim;
        reg [12:0] q;
        begin
            q = v >> s;
            shr_sat = (q > lim) ? lim : q;
        end
    endfunction

    // Byte-lane merge of the write data over the present word.
    function [31:0] lane_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] be;
        integer b;
        begin
            lane_merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (be[b]) lane_merge[8*b +: 8] = nw[8*b +: 8];
            end
        end
    endfunction

    function [8:0] mse_of;
        input [12:0] v;
        input [4:0] s;
        reg [12:0] t;
        begin
            t = shr_sat(v, s, `CQM_MSE_MAX);
            mse_of = t[8:0];
        end
    endfunction

    function [5:0] pk_of;
        input [12:0] v;
        input [4:0] s;
        reg [12:0] t;
        begin
            t = shr_sat(v, s + `CQM_PEAK_EXTRA_SHIFT, `CQM_PEAK_MAX);
            pk_of = t[5:0];
        end
    endfunction

    assign meas_en = config_reg[`CQM_BIT_ENABLE];
    assign step = sym_valid_in & meas_en;
    assign period_end = step & (sym_cnt_reg == `CQM_PERIOD_LAST);
    assign mean_os = {1'b0, config_reg[`CQM_FLD_MEAN_OUTPUT_SHIFT]};
    assign peak_os = {1'b0, config_reg[`CQM_FLD_PEAK_OUTPUT_SHIFT]};

    // One wait cycle per access; the second cycle completes it.
    assign req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = req & ~ack_reg;
    assign wr_ack = avs_write_in & ack_reg;
    assign rd_ack = avs_read_in & ack_reg;
    assign capture = wr_ack & (avs_address_in == `CQM_OFS_CONFIG) &
        avs_byteenable_in[0] & avs_writedata_in[`CQM_BIT_CAPTURE];

    // Every pair has its own error term, mean filter and peak filter.
    genvar g;
    generate
        for (g = 0; g < PAIRS; g = g + 1) begin : pair
            assign term_w[g] = err_term(sample_in[9*g +: 9],
                config_reg[`CQM_BIT_GIGABIT],
                config_reg[`CQM_BIT_SQUARE]);
            cqm_lpf #(.IW(13), .FW(FRAC)) mean_lpf (
                .clk_sys_in(clk_sys_in),
                .rstn_in(rstn_in),
                .step_in(step),
                .term_in(term_w[g]),
                .shift_in(config_reg[`CQM_FLD_MEAN_FILTER_SHIFT]),
                .state_out(mean_w[g])
            );
            cqm_lpf #(.IW(13), .FW(FRAC)) peak_lpf (
                .clk_sys_in(clk_sys_in),
                .rstn_in(rstn_in),
                .step_in(step),
                .term_in(term_w[g]),
                .shift_in(config_reg[`CQM_FLD_PEAK_FILTER_SHIFT]),
                .state_out(peak_w[g])
            );
        end
    endgenerate

    // Quality indices are derived from captured errors, current and worst.
    cqm_quality cur_quality (
        .mse_in(cap_qmse_reg),
        .thresh_in(thresh_reg),
        .index_out(cap_q_w)
    );
    cqm_quality worst_quality (
        .mse_in(cap_wqmse_reg),
        .thresh_in(thresh_reg),
        .index_out(cap_wq_w)
    );

    // Present value of the addressed register, used for reads and merges.
    always @* begin
        cur_word = 32'h0000_0000;
        if (avs_address_in == `CQM_OFS_CONFIG) begin
            cur_word = config_reg;
            cur_word[`CQM_BIT_CAPTURE] = 1'b0;
        end else if (avs_address_in >= `CQM_OFS_THRESH1 &&
                     avs_address_in <= `CQM_OFS_THRESH7 &&
                     avs_address_in[1:0] == 2'b00) begin
            cur_word[8:0] = thresh_reg[9*(avs_address_in[4:2]-3'h1) +: 9];
        end else if (avs_address_in == `CQM_OFS_MSE) begin
            cur_word[8:0] = cap_mse_reg;
        end else if (avs_address_in == `CQM_OFS_MSE_WORST) begin
            cur_word[8:0] = cap_wmse_reg;
        end else if (avs_address_in == `CQM_OFS_QUALITY) begin
            cur_word[2:0] = cap_q_w;
            cur_word[6:4] = cap_wq_w;
        end else if (avs_address_in == `CQM_OFS_SLICER) begin
            cur_word[12:0] = cap_slicer_reg;
        end else if (avs_address_in == `CQM_OFS_PEAK) begin
            cur_word[5:0] = cap_pk_reg;
            cur_word[13:8] = cap_wpk_reg;
        end
        wr_word = lane_merge(cur_word, avs_writedata_in, avs_byteenable_in);
    end

    // Bus handshake and read data; data is captured on the wait cycle.
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_reg <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (avs_read_in & ~ack_reg) begin
                avs_readdata_out <= cur_word;
            end
        end
    end

    // Software-written configuration and quality thresholds.
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            config_reg <= `CQM_CONFIG_RESET;
            thresh_reg <= {7{`CQM_THRESH_RESET}};
        end else if (wr_ack) begin
            if (avs_address_in == `CQM_OFS_CONFIG) begin
                // Capture never stores, so it reads back as zero.
                config_reg <= wr_word & `CQM_CONFIG_WMASK;
            end else if (avs_address_in >= `CQM_OFS_THRESH1 &&
                         avs_address_in <= `CQM_OFS_THRESH7 &&
                         avs_address_in[1:0] == 2'b00) begin
                thresh_reg[9*(avs_address_in[4:2]-3'h1) +: 9] <=
                    wr_word[8:0];
            end
        end
    end

    // Symbol counter marks the end of each measurement period.
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sym_cnt_reg <= 16'h0000;
        end else if (step) begin
            sym_cnt_reg <= sym_cnt_reg + 16'h0001;
        end
    end

    // Per-pair latches, peak tracking and worst-case holding.
    // A period end in the same cycle as a clearing read still counts:
    // the clear restarts from the current value and the new one is folded.
    always @(posedge clk_sys_in or negedge rstn_in) begin : per_pair
        reg [8:0] base_m;
        reg [8:0] base_q;
        reg [5:0] base_p;
        reg [8:0] new_m;
        reg [5:0] new_p;
        reg [12:0] new_pk;
        reg sel;
        if (!rstn_in) begin
            for (p = 0; p < PAIRS; p = p + 1) begin
                lat_reg[p] <= 13'h0000;
                pk_run_reg[p] <= 13'h0000;
                pk_sav_reg[p] <= 13'h0000;
                worst_mse_reg[p] <= 9'h000;
                worst_qmse_reg[p] <= 9'h000;
                worst_pk_reg[p] <= 6'h00;
            end
        end else begin
            for (p = 0; p < PAIRS; p = p + 1) begin
                sel = (cap_pair_reg == p[1:0]) & rd_ack;
                new_pk = (peak_w[p] > pk_run_reg[p]) ?
                    peak_w[p] : pk_run_reg[p];
                new_m = mse_of(mean_w[p], mean_os);
                new_p = pk_of(new_pk, peak_os);
                base_m = (sel && avs_address_in == `CQM_OFS_MSE) ?
                    mse_of(lat_reg[p], mean_os) : worst_mse_reg[p];
                base_q = (sel && avs_address_in == `CQM_OFS_QUALITY) ?
                    mse_of(lat_reg[p], mean_os) : worst_qmse_reg[p];
                base_p = (sel && avs_address_in == `CQM_OFS_PEAK) ?
                    pk_of(pk_sav_reg[p], peak_os) : worst_pk_reg[p];
                if (step) begin
                    pk_run_reg[p] <= new_pk;
                end
                if (period_end) begin
                    lat_reg[p] <= mean_w[p];
                    pk_sav_reg[p] <= new_pk;
                    pk_run_reg[p] <= 13'h0000;
                    worst_mse_reg[p] <= (new_m > base_m) ? new_m : base_m;
                    worst_qmse_reg[p] <= (new_m > base_q) ? new_m : base_q;
                    worst_pk_reg[p] <= (new_p > base_p) ? new_p : base_p;
                end else begin
                    worst_mse_reg[p] <= base_m;
                    worst_qmse_reg[p] <= base_q;
                    worst_pk_reg[p] <= base_p;
                end
            end
        end
    end

    // Capture copies the selected pair's results into the result registers.
    always @(posedge clk_sys_in or negedge rstn_in) begin : snapshot
        reg [1:0] ch;
        if (!rstn_in) begin
            cap_pair_reg <= 2'h0;
            cap_mse_reg <= 9'h000;
            cap_wmse_reg <= 9'h000;
            cap_qmse_reg <= 9'h000;
            cap_wqmse_reg <= 9'h000;
            cap_slicer_reg <= 13'h0000;
            cap_pk_reg <= 6'h00;
            cap_wpk_reg <= 6'h00;
        end else if (capture) begin
            // The pair number is only meaningful on a capturing write.
            ch = avs_writedata_in[`CQM_FLD_CHANNEL];
            cap_pair_reg <= ch;
            cap_mse_reg <= mse_of(lat_reg[ch], mean_os);
            cap_wmse_reg <= worst_mse_reg[ch];
            cap_qmse_reg <= mse_of(lat_reg[ch], mean_os);
            cap_wqmse_reg <= worst_qmse_reg[ch];
            cap_slicer_reg <= lat_reg[ch];
            cap_pk_reg <= pk_of(pk_sav_reg[ch], peak_os);
            cap_wpk_reg <= worst_pk_reg[ch];
        end
    end
endmodule // cqm_monitor
`default_nettype wire

// ===== tb/cqm_monitor_checker.sv
// Concurrent checks on the register bus ports of the channel quality monitor.
`timescale 1ns/1ns
`default_nettype none
`include "cqm_regs.vh"
module cqm_monitor_checker #(
    parameter PAIRS = 4,
    parameter FRAC = 16
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);

    // A bus transfer is a waiting request followed by its answer.
    sequence s_wait;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_ack;
        !avs_waitrequest_out;
    endsequence
    // Completion of a read; read data are only meaningful in this cycle.
    sequence s_rd(logic [5:0] a);
        avs_read_in && !avs_waitrequest_out && avs_address_in == a;
    endsequence

    // Bus handshake and self-clearing capture bit.
    AST_ONE_WAIT: assert property (s_wait |=> s_ack)
        else $error("Request was not answered after one wait cycle.");
    AST_IDLE_NO_WAIT: assert property (
        !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
        else $error("Wait request raised without a request.");
    AST_CAPTURE_CLEARS: assert property (s_rd(`CQM_OFS_CONFIG) |->
        avs_readdata_out[`CQM_BIT_CAPTURE] == 1'b0)
        else $error("Capture bit read back high.");
    // Result fields never leave their documented ranges, and worst quality and peak values never beat current ones.
    AST_MSE_LIMIT: assert property (s_rd(`CQM_OFS_MSE) |->
        avs_readdata_out[31:9] == 23'h000000)
        else $error("Mean square error above its range.");
    AST_MSE_WORST_LIMIT: assert property (s_rd(`CQM_OFS_MSE_WORST) |->
        avs_readdata_out[31:9] == 23'h000000)
        else $error("Worst mean square error above its range.");
    AST_QUALITY_FIELDS: assert property (s_rd(`CQM_OFS_QUALITY) |->
        avs_readdata_out[31:7] == 25'h0000000 && !avs_readdata_out[3])
        else $error("Quality register holds bits outside its fields.");
    AST_QUALITY_LOWEST: assert property (s_rd(`CQM_OFS_QUALITY) |->
        avs_readdata_out[6:4] <= avs_readdata_out[2:0])
        else $error("Worst quality index above current index.");
    AST_SLICER_LIMIT: assert property (s_rd(`CQM_OFS_SLICER) |->
        avs_readdata_out[31:13] == 19'h00000)
        else $error("Mean slicer error above its width.");
    AST_PEAK_LIMIT: assert property (s_rd(`CQM_OFS_PEAK) |->
        avs_readdata_out[31:14] == 18'h00000 && avs_readdata_out[7:6] == 2'h0)
        else $error("Peak error above its range.");
    AST_PEAK_WORST: assert property (s_rd(`CQM_OFS_PEAK) |->
        avs_readdata_out[13:8] >= avs_readdata_out[5:0])
        else $error("Worst peak error below current peak error.");
endmodule // cqm_monitor_checker

bind cqm_monitor cqm_monitor_checker #(
    .PAIRS(PAIRS),
    .FRAC(FRAC)
) cqm_monitor_checker_inst (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out)
);
`default_nettype wire

// ===== tb/cqm_slicer_model.sv
// Receive slicer model that hands one sample per pair on every symbol.
`timescale 1ns/1ns
`default_nettype none
module cqm_slicer_model (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic run_in,
    input wire logic [35:0] level_in,
    output logic sym_valid_out,
    output logic [35:0] sample_out
);
    // Symbols come every clock while running; between runs the sample bus
    // is not held, so it toggles to keep a stale value from looking valid.
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sym_valid_out <= 1'b0;
            sample_out <= 36'h000000000;
        end else if (run_in) begin
            sym_valid_out <= 1'b1;
            sample_out <= level_in;
        end else begin
            sym_valid_out <= 1'b0;
            sample_out <= ~sample_out;
        end
    end
endmodule // cqm_slicer_model
`default_nettype wire

// ===== tb/cqm_monitor_tb.sv
// Self-checking testbench for the channel quality monitor.
`timescale 1ns/1ns
`default_nettype none
`include "cqm_regs.vh"
module cqm_monitor_tb;
    logic clk_sys_in;
    logic rstn_in;
    logic run;
    logic [35:0] level;
    logic sym_valid;
    logic [35:0] sample;
    logic [5:0] avs_address_in;
    logic avs_read_in;
    logic avs_write_in;
    logic [3:0] avs_byteenable_in;
    logic [31:0] avs_writedata_in;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [31:0] rd_data;
    logic [31:0] cfg;
    integer err_count;
    integer check_count;
    integer smp [0:3];
    integer th [1:7];
    integer p;
    integer t;
    integer q;
    integer pk;

    cqm_slicer_model cqm_slicer_model_inst (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .run_in(run),
        .level_in(level),
        .sym_valid_out(sym_valid),
        .sample_out(sample)
    );
    cqm_monitor cqm_monitor_inst (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .sym_valid_in(sym_valid),
        .sample_in(sample),
        .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in),
        .avs_byteenable_in(avs_byteenable_in),
        .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out)
    );

    // Free-running 20 MHz system clock.
    always #25 clk_sys_in = ~clk_sys_in;

    task results;
        begin
            $display("Checks %0d, errors %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // One Avalon transfer; the request is held until wait request is low,
    // and the extra leading edge keeps two drives of a strobe apart.
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge clk_sys_in);
            avs_address_in <= a;
            avs_writedata_in <= d;
            avs_write_in <= wr;
            avs_read_in <= !wr;
            @(posedge clk_sys_in);
            while (avs_waitrequest_out !== 1'b0 && n < 50) begin
                @(posedge clk_sys_in);
                n = n + 1;
            end
            rd_data = avs_readdata_out;
            avs_write_in <= 1'b0;
            avs_read_in <= 1'b0;
            if (n >= 50) begin
                err_count = err_count + 1;
                $display("ERROR at %0t: bus answer timed out", $time);
                results;
            end
        end
    endtask

    // Error term of one sample in gigabit square mode, nearest level taken.
    function automatic integer term_of(input integer s);
        integer e;
        begin
            if (s < -64) e = s + 96;
            else if (s < 0) e = s + 32;
            else if (s < 64) e = s - 32;
            else e = s - 96;
            if (e < 0) e = -e;
            if (e > 32) e = 32;
            term_of = (2 * e) * (2 * e);
        end
    endfunction

    function automatic integer lim(input integer v, input integer m);
        lim = (v > m) ? m : v;
    endfunction

    // Thresholds fall with n, so the last one still met gives the index.
    function automatic integer qi(input integer m);
        integer n;
        begin
            qi = 0;
            for (n = 1; n <= 7; n = n + 1) begin
                if (m <= th[n]) qi = n;
            end
        end
    endfunction

    // Main sequence: setup, a disabled run, one full period, then captures.
    initial begin
        clk_sys_in = 1'b0;
        rstn_in = 1'b0;
        run = 1'b0;
        avs_address_in = 6'h00;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_byteenable_in = 4'hF;
        avs_writedata_in = 32'h00000000;
        err_count = 0;
        check_count = 0;
        smp = '{101, -42, 72, 255};
        th = '{500, 400, 300, 200, 100, 50, 20};
        // Largest error on every pair until the enabled run starts.
        level = {4{9'h0FF}};
        repeat (8) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        for (p = 1; p <= 7; p = p + 1) begin
            bus(1'b1, `CQM_OFS_THRESH1 + 6'(4 * (p - 1)), 32'(th[p]));
        end
        bus(1'b0, `CQM_OFS_THRESH7, 32'h00000000);
        check(rd_data, 32'(th[7]));
        bus(1'b1, 6'h3C, 32'hFFFFFFFF);
        bus(1'b0, 6'h3C, 32'h00000000);
        check(rd_data, 32'h00000000);
        // Symbols while measurement is off must leave the mean square, slicer and peak results at zero.
        // Their large squared error would also spoil the later peak results.
        bus(1'b1, `CQM_OFS_CONFIG, 32'h00000006);
        run <= 1'b1;
        repeat (20) @(posedge clk_sys_in);
        run <= 1'b0;
        bus(1'b1, `CQM_OFS_CONFIG, 32'h0000003E);
        bus(1'b0, `CQM_OFS_MSE, 32'h00000000);
        check(rd_data, 32'h00000000);
        bus(1'b0, `CQM_OFS_SLICER, 32'h00000000);
        check(rd_data, 32'h00000000);
        bus(1'b0, `CQM_OFS_PEAK, 32'h00000000);
        check(rd_data, 32'h00000000);
        // Enable, square, gigabit; shifts 0, mean scale 2, peak scale 1.
        cfg = 32'h00120007;
        bus(1'b1, `CQM_OFS_CONFIG, cfg);
        level <= {9'(smp[3]), 9'(smp[2]), 9'(smp[1]), 9'(smp[0])};
        run <= 1'b1;
        repeat (`CQM_PERIOD_SYMBOLS + 10) @(posedge clk_sys_in);
        run <= 1'b0;
        for (p = 0; p < 4; p = p + 1) begin
            t = term_of(smp[p]);
            q = qi(lim(t / 4, 32'h1FF));
            pk = lim(t / 16, 32'h3F);
            bus(1'b1, `CQM_OFS_CONFIG, cfg | 32'h8 | 32'(p * 16));
            bus(1'b0, `CQM_OFS_CONFIG, 32'h00000000);
            check(rd_data, cfg | 32'(p * 16));
            bus(1'b0, `CQM_OFS_MSE, 32'h00000000);
            check(rd_data, 32'(lim(t / 4, 32'h1FF)));
            bus(1'b0, `CQM_OFS_MSE_WORST, 32'h00000000);
            check(rd_data, 32'(lim(t / 4, 32'h1FF)));
            bus(1'b0, `CQM_OFS_QUALITY, 32'h00000000);
            check(rd_data, 32'(q * 16 + q));
            bus(1'b0, `CQM_OFS_SLICER, 32'h00000000);
            check(rd_data, 32'(t));
            bus(1'b0, `CQM_OFS_PEAK, 32'h00000000);
            check(rd_data, 32'(pk * 256 + pk));
        end
        results;
    end
endmodule // cqm_monitor_tb
`default_nettype wire
